// ===== stepper_regs.vh
`ifndef STEPPER_REGS_VH
`define STEPPER_REGS_VH

// Register addresses (7-bit serial address)
`define ADDR_CONFIG 7'h00
`define ADDR_FLAGS 7'h01
`define ADDR_PINS 7'h04
`define ADDR_COIL_DIRECT 7'h2d

// Serial datagram layout
`define FRAME_BITS 6'd40
`define FRAME_LAST 6'd39
`define FRAME_OVER 6'd41
`define WRITE_BIT 39
`define ADDR_MSB 38
`define ADDR_LSB 32

// Configuration field positions
`define CFG_WIDTH 18
`define CFG_SMALL_HYST 14
`define CFG_STOP_EN 15
`define CFG_DIRECT 16
`define CFG_TEST 17
`define CFG_RESET 18'h00000

// Global flag positions
`define FLAG_RESET 0
`define FLAG_DRV_ERR 1
`define FLAG_PUMP_UV 2
`define FLAGS_AT_RESET 3'h1

// Direct coil register fields
`define COIL_A_MSB 8
`define COIL_B_LSB 16
`define COIL_B_MSB 24
`define COIL_DIRECT_RESET 32'h00000000

// Input pin readback layout
`define PIN_FIXED_ONE 1'h1
`define REV_MSB 31
`define REV_LSB 24

// Hysteresis shifts (1/16 and 1/32)
`define HYST_SHIFT_WIDE 4
`define HYST_SHIFT_NARROW 5

// Standstill scale: (scale+1)/32
`define SCALE_SHIFT 5
// Top product bit kept after the shift
`define SCALED_MSB 13

// Probe selections
`define PROBE_TEMP 2'h0
`define PROBE_DAC 2'h1
`define PROBE_HIGH_RAIL 2'h2

`endif

// ===== serial_frame_port.v
`timescale 1ns/10ps
`include "stepper_regs.vh"

// 40-bit serial datagram engine, pins sampled on the system clock
module serial_frame_port (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Serial pins
    input wire sck,
    input wire csN,
    input wire mosi,
    output reg miso,
    output wire misoOe,
    // Internal side
    input wire [39:0] txWord,
    output reg frameStart,
    output reg frameDone,
    output reg [39:0] rxWord_q
);
    reg sckPrev_q; // Last sampled serial clock
    reg csPrev_q; // Last sampled chip select
    reg [39:0] shift_q; // Outgoing bits
    reg [5:0] count_q; // Bits received in this frame

    wire sckRise = sck & ~sckPrev_q;
    wire sckFall = ~sck & sckPrev_q;
    wire csFall = ~csN & csPrev_q;
    wire csRise = csN & ~csPrev_q;

    // Drive MISO only while selected
    assign misoOe = ~csN;

    // Shift in on rising, out on falling edges
    always @(posedge ref_clk) begin
        if (rst) begin
            sckPrev_q <= 1'b0;
            csPrev_q <= 1'b1;
            shift_q <= 40'h0000000000;
            count_q <= 6'h00;
            rxWord_q <= 40'h0000000000;
            miso <= 1'b0;
            frameStart <= 1'b0;
            frameDone <= 1'b0;
        end else begin
            sckPrev_q <= sck;
            csPrev_q <= csN;
            frameStart <= csFall;
            // Only a whole 40-bit frame counts
            frameDone <= csRise && (count_q == `FRAME_BITS);
            if (csFall) begin
                // Load reply, first bit out at once
                shift_q <= {txWord[38:0], 1'b0};
                miso <= txWord[`FRAME_LAST];
                count_q <= 6'h00;
            end else if (~csN) begin
                if (sckRise) begin
                    rxWord_q <= {rxWord_q[38:0], mosi};
                    // Count one past 40 so an overlong frame is refused
                    if (count_q != `FRAME_OVER) begin
                        count_q <= count_q + 6'h01;
                    end
                end
                if (sckFall) begin
                    miso <= shift_q[`FRAME_LAST];
                    shift_q <= {shift_q[38:0], 1'b0};
                end
            end
        end
    end
endmodule // serial_frame_port

// ===== stepper_global_config_status.v
// How it works
// - Hysteresis 1/16, or 1/32 when bit set
// - Halt pin stops sequencer when enabled
// - Direct mode takes coil values from register
// - Direct currents scaled; velocity regulation disabled
// - Test bit routes selected analog probe
// - Flags readable; write one clears
// - Reset sets flag bit zero
// - Driver shutdown sets flag bit one
// - Fault clear needs temperature below limit
// - Pump undervoltage latches bit two, disables driver
// - Pin readback returns live pin states
// - Top byte returns fixed revision code
`timescale 1ns/10ps
`include "stepper_regs.vh"

module stepper_global_config_status #(
    parameter [7:0] REV_CODE = 8'h01, // Arbitrary revision value
    parameter PERIOD_W = 20 // Step period measurement width
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Serial register port
    input wire sck,
    input wire csN,
    input wire mosi,
    output wire miso,
    output wire misoOe,
    // Input pins
    input wire stepPin,
    input wire dirPin,
    input wire dc_enable_cfg_pin,
    input wire dc_input_cfg_pin,
    input wire driver_disable_pin,
    input wire dc_output_cfg_pin,
    input wire halt_input_pin,
    // Driver and protection status
    input wire overTemp,
    input wire shortDetect,
    input wire pumpUndervoltage,
    // Current setting and step rate
    input wire [4:0] standstill_current_scale,
    input wire [PERIOD_W-1:0] stepPeriod,
    input wire [PERIOD_W-1:0] periodThreshold,
    // Sequencer control
    output reg sequencerHalt,
    output reg forceStandstill,
    output reg aboveThreshold,
    // Coil drive
    output reg directMode,
    output reg signed [8:0] coilA,
    output reg signed [8:0] coilB,
    output reg velocityRegEnable,
    output reg autoRegLowVelOnly,
    output reg driverEnable,
    // Analog probe
    output reg probeEnable,
    output reg [2:0] probe_output_pin_sel,
    // Flag view
    output wire [2:0] flagsOut
);
    reg [`CFG_WIDTH-1:0] global_configuration_q; // Upper config bits
    reg [2:0] global_flags_q; // Sticky status flags
    reg [2:0] global_flags_d; // Next flag value
    reg [31:0] coil_current_direct_reg_q; // Direct coil values
    reg [6:0] readAddr_q; // Address of last datagram
    reg [31:0] readMux; // Reply data
    reg [31:0] pinWord; // Live pin readback
    reg [PERIOD_W:0] hyst; // Hysteresis band
    reg [PERIOD_W:0] lowEdge; // Lower switching point
    reg [PERIOD_W:0] highEdge; // Upper switching point

    wire [39:0] rxWord; // Last 40 bits shifted in, whole frame or not
    wire frameDone; // One-cycle strobe after a 40-bit frame
    wire [6:0] rxAddr; // Register address field
    wire rxWrite; // Write flag of the datagram
    wire [31:0] rxData; // Data field of the datagram
    wire wrCfg; // Write strobe, configuration
    wire wrFlags; // Write strobe, flag clear
    wire wrDirect; // Write strobe, direct coil register
    wire shutdownEvent; // Live driver shutdown cause

    // Datagram fields of the frame just taken
    assign rxAddr = rxWord[`ADDR_MSB:`ADDR_LSB];
    assign rxWrite = rxWord[`WRITE_BIT];
    assign rxData = rxWord[31:0];

    // Writes act only on a whole frame with the write bit set
    assign wrCfg = frameDone & rxWrite & (rxAddr == `ADDR_CONFIG);
    assign wrFlags = frameDone & rxWrite & (rxAddr == `ADDR_FLAGS);
    // The pin readback address has no strobe, so writes there vanish
    assign wrDirect = frameDone & rxWrite & (rxAddr == `ADDR_COIL_DIRECT);

    // Either protection cause shuts the driver down
    assign shutdownEvent = overTemp | shortDetect;

    // Scaled direct coil currents; factor runs 1..32, seven bits keep it positive
    wire signed [6:0] scaleFactor; // Standstill scale plus one
    wire signed [15:0] prodA; // Coil A times factor
    wire signed [15:0] prodB; // Coil B times factor
    assign scaleFactor = {2'b00, standstill_current_scale} + 7'h01;
    assign prodA = $signed(coil_current_direct_reg_q[`COIL_A_MSB:0]) * scaleFactor;
    assign prodB = $signed(coil_current_direct_reg_q[`COIL_B_MSB:`COIL_B_LSB]) * scaleFactor;

    assign flagsOut = global_flags_q;

    // Serial datagram engine
    serial_frame_port serial_frame_port_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .sck(sck),
        .csN(csN),
        .mosi(mosi),
        .miso(miso),
        .misoOe(misoOe),
        .txWord({5'h00, global_flags_q, readMux}),
        .frameStart(),
        .frameDone(frameDone),
        .rxWord_q(rxWord)
    );

    // Live pin readback word
    always @* begin
        // Bit 7 and the middle bytes read zero
        pinWord = 32'h00000000;
        pinWord[0] = stepPin;
        pinWord[1] = dirPin;
        pinWord[2] = dc_enable_cfg_pin;
        pinWord[3] = dc_input_cfg_pin;
        pinWord[4] = driver_disable_pin;
        pinWord[5] = dc_output_cfg_pin;
        pinWord[6] = `PIN_FIXED_ONE;
        pinWord[`REV_MSB:`REV_LSB] = REV_CODE;
    end

    // Reply data for the address of the previous datagram
    always @* begin
        case (readAddr_q)
            `ADDR_CONFIG: begin
                // Unused upper bits read zero
                readMux = {14'h0000, global_configuration_q};
            end
            `ADDR_FLAGS: begin
                readMux = {29'h00000000, global_flags_q};
            end
            `ADDR_PINS: begin
                // Read-only live pins and revision byte
                readMux = pinWord;
            end
            `ADDR_COIL_DIRECT: begin
                // Both coil fields as written
                readMux = coil_current_direct_reg_q;
            end
            default: begin
                // Unmapped addresses read zero
                readMux = 32'h00000000;
            end
        endcase
    end

    // Flag update: events set, written ones clear, set wins
    always @* begin
        global_flags_d = global_flags_q;
        if (wrFlags) begin
            // Written ones clear, written zeros leave a flag alone
            global_flags_d[`FLAG_RESET] = global_flags_q[`FLAG_RESET] & ~rxData[`FLAG_RESET];
            global_flags_d[`FLAG_PUMP_UV] = global_flags_q[`FLAG_PUMP_UV] & ~rxData[`FLAG_PUMP_UV];
            // Fault clear blocked while still hot
            if (rxData[`FLAG_DRV_ERR] && !overTemp) begin
                global_flags_d[`FLAG_DRV_ERR] = 1'b0;
            end
        end
        if (shutdownEvent) begin
            global_flags_d[`FLAG_DRV_ERR] = 1'b1;
        end
        if (pumpUndervoltage) begin
            global_flags_d[`FLAG_PUMP_UV] = 1'b1;
        end
    end

    // Register file and address tracking
    always @(posedge ref_clk) begin
        if (rst) begin
            global_configuration_q <= `CFG_RESET;
            global_flags_q <= `FLAGS_AT_RESET;
            coil_current_direct_reg_q <= `COIL_DIRECT_RESET;
            readAddr_q <= 7'h00;
        end else begin
            // Flags take their next value every cycle
            global_flags_q <= global_flags_d;
            // All eighteen configuration bits are stored
            if (wrCfg) begin
                global_configuration_q <= rxData[`CFG_WIDTH-1:0];
            end
            if (wrDirect) begin
                coil_current_direct_reg_q <= rxData;
            end
            if (frameDone) begin
                // The next reply answers this address
                readAddr_q <= rxAddr;
            end
        end
    end

    // Hysteresis band around the step rate threshold
    always @* begin
        // Narrow band when the small hysteresis bit is set
        if (global_configuration_q[`CFG_SMALL_HYST]) begin
            hyst = {1'b0, periodThreshold} >> `HYST_SHIFT_NARROW;
        end else begin
            hyst = {1'b0, periodThreshold} >> `HYST_SHIFT_WIDE;
        end
        // Switching points on either side of the threshold
        lowEdge = {1'b0, periodThreshold} - hyst;
        highEdge = {1'b0, periodThreshold} + hyst;
    end

    // Step rate comparison, shorter period means faster
    always @(posedge ref_clk) begin
        if (rst) begin
            aboveThreshold <= 1'b0;
        end else if (!aboveThreshold && ({1'b0, stepPeriod} < lowEdge)) begin
            // Period below the lower point: faster than threshold
            aboveThreshold <= 1'b1;
        end else if (aboveThreshold && ({1'b0, stepPeriod} > highEdge)) begin
            // Period above the upper point: slower again
            aboveThreshold <= 1'b0;
        end
    end

    // Emergency halt: the pin acts only while the stop enable bit is set
    always @(posedge ref_clk) begin
        if (rst) begin
            sequencerHalt <= 1'b0;
            forceStandstill <= 1'b0;
        end else begin
            sequencerHalt <= global_configuration_q[`CFG_STOP_EN] & halt_input_pin;
            // Standstill follows the halt in the same cycle
            forceStandstill <= global_configuration_q[`CFG_STOP_EN] & halt_input_pin;
        end
    end

    // Direct coil drive, values scaled by the standstill setting
    always @(posedge ref_clk) begin
        if (rst) begin
            directMode <= 1'b0;
            coilA <= 9'sh000;
            coilB <= 9'sh000;
        end else begin
            directMode <= global_configuration_q[`CFG_DIRECT];
            if (global_configuration_q[`CFG_DIRECT]) begin
                // Dropping five low bits divides by 32, rounding down
                coilA <= prodA[`SCALED_MSB:`SCALE_SHIFT];
                coilB <= prodB[`SCALED_MSB:`SCALE_SHIFT];
            end else begin
                // Outside direct drive the coil values rest at zero
                coilA <= 9'sh000;
                coilB <= 9'sh000;
            end
        end
    end

    // Current regulation modes, restricted during direct drive
    always @(posedge ref_clk) begin
        if (rst) begin
            velocityRegEnable <= 1'b1;
            autoRegLowVelOnly <= 1'b0;
        end else begin
            velocityRegEnable <= ~global_configuration_q[`CFG_DIRECT];
            autoRegLowVelOnly <= global_configuration_q[`CFG_DIRECT];
        end
    end

    // Driver off during undervoltage or a live shutdown cause
    always @(posedge ref_clk) begin
        if (rst) begin
            driverEnable <= 1'b0;
        end else begin
            driverEnable <= ~pumpUndervoltage & ~shutdownEvent;
        end
    end

    // Analog probe routing in test mode
    always @(posedge ref_clk) begin
        if (rst) begin
            probeEnable <= 1'b0;
            probe_output_pin_sel <= 3'h0;
        end else begin
            probeEnable <= global_configuration_q[`CFG_TEST];
            if (!global_configuration_q[`CFG_TEST]) begin
                // Probe pin stays quiet outside test mode
                probe_output_pin_sel <= 3'h0;
            end else begin
                case (standstill_current_scale[1:0])
                    `PROBE_TEMP: begin
                        probe_output_pin_sel <= 3'h1;
                    end
                    `PROBE_DAC: begin
                        probe_output_pin_sel <= 3'h2;
                    end
                    `PROBE_HIGH_RAIL: begin
                        probe_output_pin_sel <= 3'h4;
                    end
                    default: begin
                        // Code 3 selects nothing
                        probe_output_pin_sel <= 3'h0;
                    end
                endcase
            end
        end
    end
endmodule // stepper_global_config_status

// ===== serial_host_model.sv
`timescale 1ns/10ps
// Host processor side of the serial register port
module serial_host_model (
    // Clock
    input wire ref_clk,
    // Serial pins
    input wire miso,
    output reg sck = 1'b0,
    output reg csN = 1'b1,
    output reg mosi = 1'b0
);
    // One 40-bit datagram, MSB first; flags are cleared by writing ones back
    task automatic xfer(input [39:0] tx, output [39:0] rx);
        integer i;
        begin
            @(posedge ref_clk) csN <= 1'b0;
            for (i = 39; i >= 0; i = i - 1) begin
                @(posedge ref_clk) mosi <= tx[i];
                repeat (3) @(posedge ref_clk);
                rx[i] = miso; // Reply bit settled before our rising edge
                sck <= 1'b1;
                repeat (3) @(posedge ref_clk);
                sck <= 1'b0;
            end
            repeat (3) @(posedge ref_clk);
            csN <= 1'b1;
            mosi <= ~mosi; // Released line shows no stale bit
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule // serial_host_model

// ===== stepper_global_config_status_assertions.sv
`timescale 1ns/10ps
// Port relations of the configuration and status block
module stepper_global_config_status_assertions (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Observed inputs
    input wire csN,
    input wire halt_input_pin,
    input wire overTemp,
    input wire shortDetect,
    input wire pumpUndervoltage,
    // Observed outputs
    input wire sequencerHalt,
    input wire forceStandstill,
    input wire directMode,
    input wire velocityRegEnable,
    input wire autoRegLowVelOnly,
    input wire driverEnable,
    input wire probeEnable,
    input wire [2:0] probe_output_pin_sel,
    input wire [2:0] flagsOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_halt_needs_pin: assert property (sequencerHalt |-> $past(halt_input_pin)) else $error("halt without pin");
    a_standstill_pair: assert property (forceStandstill == sequencerHalt) else $error("standstill mismatch");
    a_reset_flag_set: assert property ($past(rst) |-> flagsOut[0]) else $error("reset flag missing");
    a_fault_flag_set: assert property (!$past(rst) && $past(overTemp | shortDetect) |-> flagsOut[1])
        else $error("fault flag missing");
    a_hot_flag_hold: assert property (overTemp && flagsOut[1] |=> flagsOut[1]) else $error("fault cleared hot");
    a_uv_flag_drive: assert property (!$past(rst) && $past(pumpUndervoltage) |-> flagsOut[2] && !driverEnable)
        else $error("undervoltage handling");
    a_flag_clear_frame: assert property (!$past(rst) && ($past(flagsOut) & ~flagsOut) != 3'h0
        |-> $past(csN) && $past(csN, 2)) else $error("flag cleared outside write");
    a_direct_mode_regs: assert property (velocityRegEnable == !directMode && autoRegLowVelOnly == directMode)
        else $error("regulation mode mismatch");
    a_probe_select_off: assert property (!probeEnable |-> probe_output_pin_sel == 3'h0)
        else $error("probe active while off");
endmodule // stepper_global_config_status_assertions

bind stepper_global_config_status stepper_global_config_status_assertions stepper_global_config_status_assertions_i (
    .ref_clk(ref_clk), .rst(rst), .csN(csN), .halt_input_pin(halt_input_pin), .overTemp(overTemp),
    .shortDetect(shortDetect), .pumpUndervoltage(pumpUndervoltage), .sequencerHalt(sequencerHalt),
    .forceStandstill(forceStandstill), .directMode(directMode), .velocityRegEnable(velocityRegEnable),
    .autoRegLowVelOnly(autoRegLowVelOnly), .driverEnable(driverEnable), .probeEnable(probeEnable),
    .probe_output_pin_sel(probe_output_pin_sel), .flagsOut(flagsOut));

// ===== stepper_global_config_status_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the configuration and status block
module stepper_global_config_status_tb_top;
    reg ref_clk = 1'b0; // System clock
    reg rst = 1'b1; // Synchronous reset
    reg [5:0] pins = 6'h00; // Live pins in readback order
    reg halt = 1'b0; // Emergency halt pin
    reg overTemp = 1'b0; // Over-temperature level
    reg shortDet = 1'b0; // Short detection
    reg pumpUv = 1'b0; // Pump undervoltage
    reg [4:0] scale = 5'h1f; // Standstill scale
    reg [19:0] period = 20'h00100; // Measured step period
    reg [39:0] rsp; // Last reply word
    wire sck, csN, mosi, miso, misoOe, seqHalt, standstill, above, directMode, velReg, autoReg, drvEn, probeEn;
    wire [8:0] coilA, coilB;
    wire [2:0] probeSel, flags;
    integer failures = 0; // Mismatch count
    integer cmp_count = 0; // Comparison count

    always #4 ref_clk = ~ref_clk; // 125 MHz

    // Device under test; revision value is arbitrary
    stepper_global_config_status #(.REV_CODE(8'h5a)) stepper_global_config_status_i (
        .ref_clk(ref_clk), .rst(rst), .sck(sck), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe),
        .stepPin(pins[0]), .dirPin(pins[1]), .dc_enable_cfg_pin(pins[2]), .dc_input_cfg_pin(pins[3]),
        .driver_disable_pin(pins[4]), .dc_output_cfg_pin(pins[5]), .halt_input_pin(halt),
        .overTemp(overTemp), .shortDetect(shortDet), .pumpUndervoltage(pumpUv),
        .standstill_current_scale(scale), .stepPeriod(period), .periodThreshold(20'h00100),
        .sequencerHalt(seqHalt), .forceStandstill(standstill), .aboveThreshold(above), .directMode(directMode),
        .coilA(coilA), .coilB(coilB), .velocityRegEnable(velReg), .autoRegLowVelOnly(autoReg),
        .driverEnable(drvEn), .probeEnable(probeEn), .probe_output_pin_sel(probeSel), .flagsOut(flags));

    // Host on the serial port
    serial_host_model serial_host_model_i (.ref_clk(ref_clk), .miso(miso), .sck(sck), .csN(csN), .mosi(mosi));

    // Compare and count
    task chk(input [39:0] got, input [39:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Register write
    task wr(input [6:0] a, input [31:0] d);
        serial_host_model_i.xfer({1'b1, a, d}, rsp);
    endtask
    // Register read; the reply comes in the following frame
    task rd(input [6:0] a);
        begin
            serial_host_model_i.xfer({1'b0, a, 32'h0}, rsp);
            serial_host_model_i.xfer({1'b0, a, 32'h0}, rsp);
        end
    endtask
    // Reset flag, then write-zero and write-one on it
    task t_reset;
        begin
            rd(7'h01);
            chk(rsp, {5'h0, 3'h1, 32'h1});
            wr(7'h01, 32'h0);
            chk(flags, 3'h1);
            wr(7'h01, 32'h1);
            chk(flags, 3'h0);
        end
    endtask
    // Halt, direct coil drive with scaling, probe selection
    task t_config;
        integer i;
        begin
            halt <= 1'b1;
            cyc(3);
            chk(seqHalt, 1'b0);
            wr(7'h00, 32'h38000);
            wr(7'h2d, 32'h004001f0);
            chk({standstill, seqHalt, directMode, velReg, autoReg, probeEn}, 6'h3b);
            chk({coilA, coilB}, {9'h1f0, 9'h040});
            scale <= 5'h0f;
            cyc(3);
            chk({coilA, coilB, probeSel}, {9'h1f8, 9'h020, 3'h0});
            for (i = 0; i < 3; i = i + 1) begin
                scale <= i[4:0];
                cyc(3);
                chk(probeSel, 3'h1 << i);
            end
            halt <= 1'b0;
            rd(7'h00);
            chk({seqHalt, rsp[31:0]}, {1'b0, 32'h38000});
        end
    endtask
    // Step rate comparison at both hysteresis widths
    task t_hyst;
        reg [62:0] pv;
        reg [6:0] ev;
        integer i;
        begin
            pv = {9'd244, 9'd239, 9'd268, 9'd273, 9'd244, 9'd260, 9'd265};
            ev = 7'b0110110;
            for (i = 0; i < 7; i = i + 1) begin
                if (i == 4) wr(7'h00, 32'h4000);
                period <= {11'h0, pv[62-9*i -: 9]};
                cyc(3);
                chk(above, ev[6-i]);
            end
        end
    endtask
    // Fault and undervoltage flags, sticky and conditioned clears
    task t_faults;
        begin
            overTemp <= 1'b1;
            cyc(2);
            wr(7'h01, 32'h2);
            chk({flags, drvEn}, 4'h4);
            overTemp <= 1'b0;
            cyc(2);
            chk(flags, 3'h2);
            wr(7'h01, 32'h2);
            chk({flags, drvEn}, 4'h1);
            shortDet <= 1'b1;
            cyc(1);
            shortDet <= 1'b0;
            pumpUv <= 1'b1;
            cyc(3);
            chk({flags, drvEn}, 4'hc);
            pumpUv <= 1'b0;
            cyc(3);
            chk(flags, 3'h6);
            wr(7'h01, 32'h4);
            chk(flags, 3'h2);
        end
    endtask
    // Pin readback, revision byte, read-only and unmapped places
    task t_pins;
        begin
            pins <= 6'h2d;
            rd(7'h04);
            chk(rsp[31:0], {8'h5a, 16'h0, 2'b01, 6'h2d});
            pins <= 6'h12;
            wr(7'h04, 32'hffffffff);
            rd(7'h04);
            chk(rsp[31:0], {8'h5a, 16'h0, 2'b01, 6'h12});
            rd(7'h10);
            chk(rsp[31:0], 32'h0);
            chk(misoOe, 1'b0);
        end
    endtask
    // Verdict and end of run
    task report_and_stop;
        begin
            if (failures == 0 && cmp_count > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        cyc(20);
        rst <= 1'b0;
        t_reset;
        t_config;
        t_hyst;
        t_faults;
        t_pins;
        report_and_stop;
    end
    // Hang guard
    initial begin
        cyc(60000);
        failures = failures + 1;
        report_and_stop;
    end
endmodule // stepper_global_config_status_tb_top
